// File: common/rmsc_regs.svh
// Offsets, fields, reset values and timing counts of the sideband control block
`ifndef RMSC_REGS_SVH
`define RMSC_REGS_SVH
// Controller registers on the AXI4-Lite slave (byte addresses)
`define RMSC_CTRL_OFS      12'h000
`define RMSC_STAT_OFS      12'h004
`define RMSC_IRQ_STAT_OFS  12'h008
`define RMSC_IRQ_MASK_OFS  12'h00c
`define RMSC_MCFG_OFS      12'h010
`define RMSC_SPI_OFS       12'h014
// Control register fields
`define RMSC_CTRL_RESET_BIT   0
`define RMSC_CTRL_WAKE_BIT    1
`define RMSC_CTRL_RADIO_BIT   2
`define RMSC_CTRL_RST_VAL     32'h0000_0001
// Status and interrupt bits, one layout for status, sticky status and mask
`define RMSC_ST_CRC_BIT    0
`define RMSC_ST_IDLE_BIT   1
`define RMSC_ST_IRQ_BIT    2
`define RMSC_ST_WIDTH      3
// Modem configuration word: GPIO alternate enable and MISO high-z enable
`define RMSC_MCFG_ALT_BIT  0
`define RMSC_MCFG_HIZ_BIT  1
`define RMSC_MCFG_RST_VAL  32'h0000_0002
// Register indices inside the modem
`define RMSC_MREG_GPIO     6'h09
`define RMSC_MREG_GPIO_ALT 7
`define RMSC_MREG_SPI      6'h07
`define RMSC_MREG_MISO_HIZ 11
// Off-to-idle time after reset release, in microseconds, and in cycles at 100 MHz
`define RMSC_CLK_MHZ       100
`define RMSC_WAKE_US       10
`define RMSC_WAKE_CYC      (`RMSC_WAKE_US * `RMSC_CLK_MHZ)
// Serial byte register: bits 7:0 data out and in, busy flag above
`define RMSC_SPI_BUSY_BIT  8
// Serial clock half period in cycles; kept slow since the slave's clock limit is low
`define RMSC_SPI_HALF_CYC  7
`endif

// File: common/rmsc_pkg.sv
// Types shared by both ends of the sideband control link
package rmsc_pkg;
   typedef enum logic [3:0] {
      RMSC_OFF   = 4'b0001,
      RMSC_IDLE  = 4'b0010,
      RMSC_LOWP  = 4'b0100,
      RMSC_ACT   = 4'b1000
   } rmsc_mode_t;
endpackage

// File: common/rmsc_if.sv
// Pin-level link between the controller and the modem sideband logic
`timescale 1ns/1ps
interface rmsc_if;
   logic wake_request_n;
   logic radio_op_enable;
   logic modem_reset_input;
   logic serial_clock_in;
   logic mosi;
   logic ce_n;
   logic miso_o;
   logic miso_oe;
   logic modem_irq;
   logic out_of_idle_pin_o;
   logic out_of_idle_pin_oe;
   logic crc_ok_pin_o;
   logic crc_ok_pin_oe;
   modport modem (
      input  wake_request_n, radio_op_enable, modem_reset_input, serial_clock_in, mosi,
             ce_n,
      output miso_o, miso_oe, modem_irq, out_of_idle_pin_o, out_of_idle_pin_oe,
             crc_ok_pin_o, crc_ok_pin_oe
   );
   modport mcu (
      output wake_request_n, radio_op_enable, modem_reset_input, serial_clock_in, mosi,
             ce_n,
      input  miso_o, miso_oe, modem_irq, out_of_idle_pin_o, out_of_idle_pin_oe,
             crc_ok_pin_o, crc_ok_pin_oe
   );
endinterface

// File: hdl/rmsc_pin_drv.sv
// Tri-state pin driver: drives a level or releases the pin
`timescale 1ns/1ps
module rmsc_pin_drv (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic drive,
   input  wire logic level,
   output logic      pin_o,
   output logic      pin_oe
);
   typedef struct packed {
      logic o;
      logic oe;
   } rmsc_pin_st_t;
   rmsc_pin_st_t s_r;
   rmsc_pin_st_t s_nxt;

   always_comb begin
      s_nxt.o  = drive & level;
      s_nxt.oe = drive;
   end

   // Released after reset: pin behaves as an input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pin_o  = s_r.o;
   assign pin_oe = s_r.oe;
endmodule

// File: hdl/rmsc_modem_end.sv
// Modem-side sideband logic: mode tracking, status GPIOs, MISO drive, interrupt
`timescale 1ns/1ps
`include "rmsc_regs.svh"
module rmsc_modem_end #(
   parameter int WAKE_CYC = `RMSC_WAKE_CYC
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   rmsc_if.modem     link,
   input  wire logic gpio_alt_en,
   input  wire logic miso_hiz_en,
   input  wire logic enter_low_power,
   input  wire logic crc_valid,
   input  wire logic irq_event,
   input  wire logic miso_data,
   output rmsc_pkg::rmsc_mode_t mode,
   output logic      radio_active
);
   import rmsc_pkg::*;
   if (WAKE_CYC < 1 || WAKE_CYC > 65535) begin : g_bad_wake
      $error("WAKE_CYC out of range");
   end

   typedef struct packed {
      rmsc_mode_t   mode;
      logic [15:0]  cnt;
      logic         irq;
      logic         miso_o;
      logic         miso_oe;
      logic         act;
   } rmsc_mdm_st_t;
   rmsc_mdm_st_t s_r;
   rmsc_mdm_st_t s_nxt;
   logic         out_idle;

   always_comb begin
      s_nxt = s_r;
      case (s_r.mode)
         RMSC_OFF: begin
            if (link.modem_reset_input) begin
               if (s_r.cnt == 16'(WAKE_CYC - 1)) begin
                  s_nxt.mode = RMSC_IDLE;
                  s_nxt.cnt  = '0;
               end else begin
                  s_nxt.cnt  = s_r.cnt + 16'h0001;
               end
            end
         end
         RMSC_IDLE: begin
            if (enter_low_power) begin
               s_nxt.mode = RMSC_LOWP;
            end else if (link.radio_op_enable) begin
               s_nxt.mode = RMSC_ACT;
            end
         end
         RMSC_LOWP: begin
            if (!link.wake_request_n) begin
               s_nxt.mode = RMSC_IDLE;
            end
         end
         RMSC_ACT: begin
            if (!link.radio_op_enable) begin
               s_nxt.mode = RMSC_IDLE;
            end
         end
         default: s_nxt.mode = RMSC_OFF;
      endcase
      if (!link.modem_reset_input) begin
         s_nxt.mode = RMSC_OFF;
         s_nxt.cnt  = '0;
      end
      s_nxt.act = (s_nxt.mode == RMSC_ACT);
      // Interrupt line only meaningful outside off mode
      s_nxt.irq = irq_event & (s_r.mode != RMSC_OFF);
      // SPI slave answers only while selected
      if (!link.ce_n && s_r.mode != RMSC_OFF) begin
         s_nxt.miso_o  = miso_data;
         s_nxt.miso_oe = 1'b1;
      end else if (!miso_hiz_en && s_r.mode != RMSC_OFF) begin
         s_nxt.miso_o  = 1'b0;
         s_nxt.miso_oe = 1'b1;
      end else begin
         s_nxt.miso_o  = 1'b0;
         s_nxt.miso_oe = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '{mode: RMSC_OFF, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign out_idle = (s_r.mode == RMSC_ACT) | (s_r.mode == RMSC_LOWP);

   // GPIOs stay inputs after reset until the alternate function is enabled
   rmsc_pin_drv u_idle_pin (
      .aclk    (aclk),
      .aresetn (aresetn),
      .drive   (gpio_alt_en & (s_r.mode != RMSC_OFF)),
      .level   (out_idle),
      .pin_o   (link.out_of_idle_pin_o),
      .pin_oe  (link.out_of_idle_pin_oe)
   );
   rmsc_pin_drv u_crc_pin (
      .aclk    (aclk),
      .aresetn (aresetn),
      .drive   (gpio_alt_en & (s_r.mode != RMSC_OFF)),
      .level   (crc_valid),
      .pin_o   (link.crc_ok_pin_o),
      .pin_oe  (link.crc_ok_pin_oe)
   );

   assign link.miso_o    = s_r.miso_o;
   assign link.miso_oe   = s_r.miso_oe;
   assign link.modem_irq = s_r.irq;
   assign mode           = s_r.mode;
   assign radio_active   = s_r.act;
endmodule

// File: hdl/rmsc_mcu_end.sv
// Controller end: AXI4-Lite registers drive the modem sideband pins
// Operation
// - Alternate enable makes crc pin CRC status
// - Alternate enable makes idle pin status
// - Low wake request returns low power to idle
// - Controller always drives its sideband inputs
// - Modem GPIOs are inputs after reset
// - Unused GPIOs driven low or grounded
// - MISO released while chip enable negated and high-z enable set
// - Cleared high-z enable drives MISO low
// - Radio enable input gates radio operations
// - Modem interrupt reaches controller interrupt input
// - Controller drives modem reset from port
// - Modem is SPI slave, controller master
// - Chip enable held low during access
// - Reset release moves modem off to idle
`timescale 1ns/1ps
`include "rmsc_regs.svh"
module rmsc_mcu_end (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq,
   output logic             gpio_alt_en,
   output logic             miso_hiz_en,
   rmsc_if.mcu              link
);
   import rmsc_pkg::*;
   if (`RMSC_SPI_HALF_CYC < 1 || `RMSC_SPI_HALF_CYC > 16) begin : g_bad_half
      $error("serial clock half period out of range");
   end

   typedef struct packed {
      logic        awrdy;
      logic        wrdy;
      logic        aw_got;
      logic        w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arrdy;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [2:0]  ctrl;
      logic [1:0]  mcfg;
      logic [`RMSC_ST_WIDTH-1:0] stat;
      logic [`RMSC_ST_WIDTH-1:0] sticky;
      logic [`RMSC_ST_WIDTH-1:0] mask;
      logic        irq;
      logic        spi_sel;
      logic        spi_sck;
      logic        spi_in;
      logic [2:0]  spi_ph;
      logic [3:0]  spi_div;
      logic [7:0]  spi_sh;
   } rmsc_mcu_st_t;
   rmsc_mcu_st_t s_r;
   rmsc_mcu_st_t s_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [`RMSC_ST_WIDTH-1:0] now;
      logic [`RMSC_ST_WIDTH-1:0] rise;
      logic [`RMSC_ST_WIDTH-1:0] clr;
      logic                      okadr;
      now   = '0;
      rise  = '0;
      clr   = '0;
      okadr = 1'b0;
      s_nxt = s_r;
      // Status pins are only valid while the modem drives them
      // Released pins read low, as if grounded
      now[`RMSC_ST_CRC_BIT]  = link.crc_ok_pin_oe & link.crc_ok_pin_o;
      now[`RMSC_ST_IDLE_BIT] = link.out_of_idle_pin_oe & link.out_of_idle_pin_o;
      now[`RMSC_ST_IRQ_BIT]  = link.modem_irq;
      rise       = now & ~s_r.stat;
      s_nxt.stat = now;

      // Write channel: address and data taken in either order
      if (s_axi_awvalid && s_r.awrdy) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
         s_nxt.awrdy  = 1'b0;
      end
      if (s_axi_wvalid && s_r.wrdy) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
         s_nxt.wrdy  = 1'b0;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         okadr = 1'b1;
         case (s_r.awaddr)
            `RMSC_CTRL_OFS: if (s_r.wstrb[0]) s_nxt.ctrl = s_r.wdata[2:0];
            `RMSC_IRQ_STAT_OFS: if (s_r.wstrb[0]) clr = s_r.wdata[`RMSC_ST_WIDTH-1:0];
            `RMSC_IRQ_MASK_OFS: if (s_r.wstrb[0]) s_nxt.mask = s_r.wdata[`RMSC_ST_WIDTH-1:0];
            `RMSC_MCFG_OFS: if (s_r.wstrb[0]) s_nxt.mcfg = s_r.wdata[1:0];
            // Ignored while a byte is under way
            `RMSC_SPI_OFS: begin
               if (s_r.wstrb[0] && !s_r.spi_sel) begin
                  s_nxt.spi_sel = 1'b1;
                  s_nxt.spi_sh  = s_r.wdata[7:0];
                  s_nxt.spi_ph  = '0;
                  s_nxt.spi_div = '0;
                  s_nxt.spi_sck = 1'b0;
               end
            end
            `RMSC_STAT_OFS: okadr = 1'b1;
            default: okadr = 1'b0;
         endcase
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = okadr ? 2'b00 : 2'b10;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.awrdy  = 1'b1;
         s_nxt.wrdy   = 1'b1;
      end
      // Serial byte: chip enable stays low from before the first clock until the last clock falls
      if (s_r.spi_sel) begin
         if (s_r.spi_div == 4'(`RMSC_SPI_HALF_CYC - 1)) begin
            s_nxt.spi_div = '0;
            s_nxt.spi_sck = ~s_r.spi_sck;
            if (!s_r.spi_sck) begin
               s_nxt.spi_in = link.miso_oe & link.miso_o;
            end else begin
               s_nxt.spi_sh = {s_r.spi_sh[6:0], s_r.spi_in};
               s_nxt.spi_ph = s_r.spi_ph + 3'h1;
               if (s_r.spi_ph == 3'h7) begin
                  s_nxt.spi_sel = 1'b0;
               end
            end
         end else begin
            s_nxt.spi_div = s_r.spi_div + 4'h1;
         end
      end
      // Set wins over a write-one clear in the same cycle
      s_nxt.sticky = (s_r.sticky & ~clr) | rise;

      // Read channel
      if (s_axi_arvalid && s_r.arrdy) begin
         s_nxt.arrdy  = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = 2'b00;
         s_nxt.rdata  = '0;
         case (s_axi_araddr)
            `RMSC_CTRL_OFS:     s_nxt.rdata[2:0] = s_r.ctrl;
            `RMSC_STAT_OFS:     s_nxt.rdata[`RMSC_ST_WIDTH-1:0] = s_r.stat;
            `RMSC_IRQ_STAT_OFS: s_nxt.rdata[`RMSC_ST_WIDTH-1:0] = s_r.sticky;
            `RMSC_IRQ_MASK_OFS: s_nxt.rdata[`RMSC_ST_WIDTH-1:0] = s_r.mask;
            `RMSC_MCFG_OFS:     s_nxt.rdata[1:0] = s_r.mcfg;
            `RMSC_SPI_OFS: begin
               s_nxt.rdata[7:0]                = s_r.spi_sh;
               s_nxt.rdata[`RMSC_SPI_BUSY_BIT] = s_r.spi_sel;
            end
            default:            s_nxt.rresp = 2'b10;
         endcase
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arrdy  = 1'b1;
      end
      s_nxt.irq = |(s_nxt.sticky & s_nxt.mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r       <= '0;
         s_r.awrdy <= 1'b1;
         s_r.wrdy  <= 1'b1;
         s_r.arrdy <= 1'b1;
         s_r.ctrl  <= 3'(`RMSC_CTRL_RST_VAL);
         s_r.mcfg  <= 2'(`RMSC_MCFG_RST_VAL);
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Every sideband input is actively driven, never floated
   assign link.modem_reset_input = ~s_r.ctrl[`RMSC_CTRL_RESET_BIT];
   assign link.wake_request_n    = ~s_r.ctrl[`RMSC_CTRL_WAKE_BIT];
   assign link.radio_op_enable   = s_r.ctrl[`RMSC_CTRL_RADIO_BIT];
   // Serial clock and data park low while chip enable is negated
   assign link.serial_clock_in   = s_r.spi_sck;
   assign link.mosi              = s_r.spi_sh[7] & s_r.spi_sel;
   assign link.ce_n              = ~s_r.spi_sel;

   assign s_axi_awready = s_r.awrdy;
   assign s_axi_wready  = s_r.wrdy;
   assign s_axi_bvalid  = s_r.bvalid;
   assign s_axi_bresp   = s_r.bresp;
   assign s_axi_arready = s_r.arrdy;
   assign s_axi_rvalid  = s_r.rvalid;
   assign s_axi_rdata   = s_r.rdata;
   assign s_axi_rresp   = s_r.rresp;
   assign irq           = s_r.irq;
   assign gpio_alt_en   = s_r.mcfg[`RMSC_MCFG_ALT_BIT];
   assign miso_hiz_en   = s_r.mcfg[`RMSC_MCFG_HIZ_BIT];
endmodule

// File: bench/rmsc_asserts.sv
// Checker of the sideband link between the controller and modem ends
`timescale 1ns/1ps
module rmsc_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wake_request_n,
   input wire logic radio_op_enable,
   input wire logic modem_reset_input,
   input wire logic serial_clock_in,
   input wire logic mosi,
   input wire logic ce_n,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic modem_irq,
   input wire logic out_of_idle_pin_o,
   input wire logic out_of_idle_pin_oe,
   input wire logic crc_ok_pin_o,
   input wire logic crc_ok_pin_oe,
   input wire logic gpio_alt_en,
   input wire logic miso_hiz_en
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Three samples cover mode register plus pin register latency
   sequence s_off; !modem_reset_input [*3]; endsequence
   sequence s_wake; (!wake_request_n && !radio_op_enable) [*3]; endsequence
   property p_rst_ctl; $rose(aresetn) |-> !modem_reset_input && wake_request_n; endproperty
   a_rst_ctl: assert property (p_rst_ctl) else $error("modem not held after reset");
   sequence s_spi_setup; (!ce_n && !serial_clock_in) [*6]; endsequence
   property p_spi_park; ce_n |-> !serial_clock_in && !mosi; endproperty
   a_spi_park: assert property (p_spi_park) else $error("spi pins not parked");
   property p_spi_setup; $fell(ce_n) |-> s_spi_setup; endproperty
   a_spi_setup: assert property (p_spi_setup) else $error("clock before select");
   property p_off; s_off |-> !miso_oe && !modem_irq; endproperty
   a_off: assert property (p_off) else $error("modem drives while in reset");
   property p_gpio_in; !gpio_alt_en [*2] |-> !crc_ok_pin_oe && !out_of_idle_pin_oe; endproperty
   a_gpio_in: assert property (p_gpio_in) else $error("gpio driven without alt");
   property p_crc_alt; $rose(crc_ok_pin_oe) |-> $past(gpio_alt_en); endproperty
   a_crc_alt: assert property (p_crc_alt) else $error("crc pin driven early");
   property p_idle_alt; $rose(out_of_idle_pin_oe) |-> $past(gpio_alt_en); endproperty
   a_idle_alt: assert property (p_idle_alt) else $error("idle pin driven early");
   property p_miso_hiz; (ce_n && miso_hiz_en) [*2] |-> !miso_oe; endproperty
   a_miso_hiz: assert property (p_miso_hiz) else $error("miso not released");
   property p_miso_low; $past(ce_n) && miso_oe |-> !miso_o; endproperty
   a_miso_low: assert property (p_miso_low) else $error("miso not low");
   property p_wake; s_wake ##0 out_of_idle_pin_oe |-> !out_of_idle_pin_o; endproperty
   a_wake: assert property (p_wake) else $error("modem stays out of idle");
endmodule

// File: bench/rmsc_bench.sv
// Self-checking bench joining the controller and modem ends
`timescale 1ns/1ps
`include "rmsc_regs.svh"
module rmsc_bench;
   import rmsc_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, rd_v;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq, alt_en, hiz_en, radio_act;
   logic        enter_lp = 1'b0, crc_v = 1'b0, irq_ev = 1'b0, miso_d = 1'b0;
   logic [1:0]  bresp, rresp, resp_v;
   rmsc_mode_t  mode;
   int          err_total = 0, samples_checked = 0, seed = 32'h0ab7;
   rmsc_if lnk();
   rmsc_mcu_end i_rmsc_mcu_end (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
      .gpio_alt_en(alt_en), .miso_hiz_en(hiz_en), .link(lnk));
   rmsc_modem_end #(.WAKE_CYC(4)) i_rmsc_modem_end (.aclk(aclk), .aresetn(aresetn),
      .link(lnk), .gpio_alt_en(alt_en), .miso_hiz_en(hiz_en), .enter_low_power(enter_lp),
      .crc_valid(crc_v), .irq_event(irq_ev), .miso_data(miso_d), .mode(mode),
      .radio_active(radio_act));
   rmsc_asserts i_rmsc_asserts (.aclk(aclk), .aresetn(aresetn),
      .wake_request_n(lnk.wake_request_n), .radio_op_enable(lnk.radio_op_enable),
      .modem_reset_input(lnk.modem_reset_input), .serial_clock_in(lnk.serial_clock_in),
      .mosi(lnk.mosi), .ce_n(lnk.ce_n), .miso_o(lnk.miso_o), .miso_oe(lnk.miso_oe),
      .modem_irq(lnk.modem_irq), .out_of_idle_pin_o(lnk.out_of_idle_pin_o),
      .out_of_idle_pin_oe(lnk.out_of_idle_pin_oe), .crc_ok_pin_o(lnk.crc_ok_pin_o),
      .crc_ok_pin_oe(lnk.crc_ok_pin_oe), .gpio_alt_en(alt_en), .miso_hiz_en(hiz_en));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic tmo;
      err_total++;
      end_sim();
   endtask
   // Address and data offered together; bready held until the answer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 40);
      if (n >= 40) tmo();
      resp_v = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 40);
      if (n >= 40) tmo();
      rd_v = rdata;
      resp_v = rresp;
      rready <= 1'b0;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_v, exp);
   endtask
   // Polls the serial byte register until busy drops
   task automatic spi_wait;
      int n;
      n = 0;
      do begin
         rd(`RMSC_SPI_OFS);
         n++;
      end while (rd_v[`RMSC_SPI_BUSY_BIT] && n < 80);
      if (n >= 80) tmo();
   endtask
   task automatic wait_mode(input rmsc_mode_t m);
      int n;
      n = 0;
      while (mode !== m && n < 60) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 60) tmo();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   function automatic logic [31:0] stat_of(input logic c, input logic i, input logic q);
      stat_of = 32'h0;
      stat_of[`RMSC_ST_CRC_BIT] = c;
      stat_of[`RMSC_ST_IDLE_BIT] = i;
      stat_of[`RMSC_ST_IRQ_BIT] = q;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(20);
      aresetn <= 1'b1;
      rchk(`RMSC_CTRL_OFS, `RMSC_CTRL_RST_VAL);
      chk(32'(lnk.modem_reset_input), 32'h0);
      rchk(`RMSC_MCFG_OFS, `RMSC_MCFG_RST_VAL);
      chk(32'(lnk.crc_ok_pin_oe), 32'h0);
      rd(12'h020);
      chk(32'(resp_v), 32'h2);
      wr(12'h020, 32'h5);
      chk(32'(resp_v), 32'h2);
      wr(`RMSC_CTRL_OFS, 32'h0);
      wait_mode(RMSC_IDLE);
      chk(32'(mode), 32'(RMSC_IDLE));
      crc_v <= 1'b1;
      cyc(3);
      rchk(`RMSC_STAT_OFS, 32'h0);
      // Alternate pins on, MISO parked low for low power
      wr(`RMSC_MCFG_OFS, 32'h1);
      cyc(3);
      chk({lnk.miso_oe, lnk.miso_o}, 32'h2);
      // Serial bytes: the slave returns miso_d on every bit
      miso_d <= 1'b1;
      repeat (3) begin
         wr(`RMSC_SPI_OFS, 32'($random(seed)));
         spi_wait();
         chk(rd_v, 32'({8{miso_d}}));
         miso_d <= 1'($random(seed));
      end
      repeat (4) begin
         crc_v <= 1'($random(seed));
         miso_d <= 1'($random(seed));
         cyc(4);
         rchk(`RMSC_STAT_OFS, stat_of(crc_v, 1'b0, 1'b0));
      end
      wr(`RMSC_CTRL_OFS, 32'h4);
      wait_mode(RMSC_ACT);
      cyc(3);
      chk(32'(radio_act), 32'h1);
      rchk(`RMSC_STAT_OFS, stat_of(crc_v, 1'b1, 1'b0));
      wr(`RMSC_CTRL_OFS, 32'h0);
      wait_mode(RMSC_IDLE);
      chk(32'(radio_act), 32'h0);
      enter_lp <= 1'b1;
      cyc(1);
      enter_lp <= 1'b0;
      wait_mode(RMSC_LOWP);
      cyc(3);
      chk(32'(lnk.out_of_idle_pin_o), 32'h1);
      wr(`RMSC_CTRL_OFS, 32'h2);
      wait_mode(RMSC_IDLE);
      chk(32'(mode), 32'(RMSC_IDLE));
      wr(`RMSC_CTRL_OFS, 32'h0);
      // Interrupt raised, cleared, then masked
      wr(`RMSC_IRQ_STAT_OFS, 32'h7);
      wr(`RMSC_IRQ_MASK_OFS, 32'h4);
      irq_ev <= 1'b1;
      cyc(5);
      chk({lnk.modem_irq, irq}, 32'h3);
      irq_ev <= 1'b0;
      wr(`RMSC_IRQ_STAT_OFS, 32'h4);
      cyc(3);
      chk(32'(irq), 32'h0);
      wr(`RMSC_IRQ_MASK_OFS, 32'h0);
      irq_ev <= 1'b1;
      cyc(5);
      irq_ev <= 1'b0;
      chk(32'(irq), 32'h0);
      rchk(`RMSC_IRQ_STAT_OFS, 32'h4);
      wr(`RMSC_MCFG_OFS, 32'h2);
      cyc(3);
      chk({lnk.miso_oe, lnk.crc_ok_pin_oe}, 32'h0);
      wr(`RMSC_CTRL_OFS, 32'h1);
      wait_mode(RMSC_OFF);
      cyc(3);
      chk(32'(lnk.out_of_idle_pin_oe), 32'h0);
      end_sim();
   end
   initial begin
      cyc(20000);
      tmo();
   end
endmodule
